// ### verilog/ubc_checksum.sv
// top of the serial byte checksum unit: registers, frame tracking, sums
// Overview of operation
// - lin mode, enable set: transmit sum adds every sent byte, pid too.
// - lin mode, enable clear: transmit sum adds every sent byte but pid.
// - other modes, enable set: transmit sum adds all bytes since a clear.
// - other modes, enable clear: transmit sum is idle and meaningless.
// - lin mode, enable set: receive sum adds every byte taken, pid too.
// - lin mode, enable clear: receive sum adds every byte taken but pid.
// - other modes, enable set: receive sum adds all bytes since a clear.
// - other modes, enable clear: receive sum is idle and meaningless.
// - receive sum is an 8-bit read/write register reset to zero.
// - transmit sum is an 8-bit read/write register reset to zero.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module ubc_checksum #(
    parameter int AW = 4,
    parameter int DW = 8
) (
    input  wire logic                     ref_clk,
    input  wire logic                     resetn,
    input  wire logic [ubc_pkg::UBC_ADDR_W-1:0] addr,
    input  wire logic [ubc_pkg::UBC_DATA_W-1:0] wr_data,
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    output logic      [ubc_pkg::UBC_DATA_W-1:0] rd_data,
    input  wire logic                     tx_frame_start,
    input  wire logic                     tx_byte_done,
    input  wire logic [ubc_pkg::UBC_DATA_W-1:0] tx_byte,
    input  wire logic                     rx_frame_start,
    input  wire logic                     rx_byte_done,
    input  wire logic [ubc_pkg::UBC_DATA_W-1:0] rx_byte,
    output logic      [ubc_pkg::UBC_DATA_W-1:0] tx_checksum,
    output logic      [ubc_pkg::UBC_DATA_W-1:0] rx_checksum,
    output logic                          lin_mode,
    output logic                          checksum_enable
);
    import ubc_pkg::*;

    // width of one frame state field inside the status word
    localparam int SW = $bits(ubc_frame_t);

    ubc_frame_t    tx_state;
    ubc_frame_t    rx_state;
    ubc_frame_t    next_tx_state;
    ubc_frame_t    next_rx_state;
    logic          tx_counts;
    logic          rx_counts;
    logic          tx_is_pid;
    logic          rx_is_pid;
    logic          wr_txsum;
    logic          wr_rxsum;
    logic          wr_ctrl;
    logic [DW-1:0] tx_count;
    logic [DW-1:0] rx_count;
    logic [DW-1:0] next_tx_count;
    logic [DW-1:0] next_rx_count;
    logic [DW-1:0] tx_pid;
    logic [DW-1:0] rx_pid;
    logic [DW-1:0] status;
    logic [DW-1:0] next_rd_data;

    // a byte is the pid only in lin mode, right after a frame start
    function automatic logic ubc_pid_slot(
        input logic       lin,
        input ubc_frame_t st
    );
        ubc_pid_slot = lin && (st == UBC_ST_PID);
    endfunction

    // decides whether a finished byte enters the running sum
    function automatic logic ubc_counts(
        input logic       lin,
        input logic       en,
        input ubc_frame_t st
    );
        logic pid;
        pid = ubc_pid_slot(lin, st);
        if (lin) begin
            ubc_counts = en || !pid;
        end else begin
            ubc_counts = en;
        end
    endfunction

    // frame walker: frame start arms the pid slot, the next byte leaves it
    function automatic ubc_frame_t ubc_walk(
        input logic       lin,
        input logic       start,
        input logic       done,
        input ubc_frame_t st
    );
        ubc_frame_t nx;
        nx = st;
        if (!lin) begin
            nx = UBC_ST_IDLE;
        end else if (start) begin
            nx = UBC_ST_PID;
        end else if (done) begin
            case (st)
                UBC_ST_IDLE: nx = UBC_ST_IDLE;
                UBC_ST_PID:  nx = UBC_ST_DATA;
                UBC_ST_DATA: nx = UBC_ST_DATA;
                default:     nx = UBC_ST_IDLE;
            endcase
        end
        ubc_walk = nx;
    endfunction

    // one register hit: strobe high at a given offset
    function automatic logic ubc_hit(
        input logic                  strobe,
        input logic [UBC_ADDR_W-1:0] a,
        input logic [UBC_ADDR_W-1:0] target
    );
        ubc_hit = strobe && (a == target);
    endfunction

    // count step: a sum write restarts it, a byte in that cycle still counts
    function automatic logic [DW-1:0] ubc_step_count(
        input logic          clr,
        input logic          add,
        input logic [DW-1:0] cnt
    );
        logic [DW-1:0] nx;
        nx = cnt;
        if (clr) begin
            nx = add ? DW'(UBC_CNT_ONE) : DW'(UBC_CNT_RST);
        end else if (add) begin
            nx = DW'(cnt + DW'(UBC_CNT_ONE));
        end
        ubc_step_count = nx;
    endfunction

    // register decode
    always_comb begin
        wr_ctrl  = 1'b0;
        wr_txsum = 1'b0;
        wr_rxsum = 1'b0;
        if (ubc_hit(wr_en, addr, UBC_ADDR_CTRL)) begin
            wr_ctrl = 1'b1;
        end else if (ubc_hit(wr_en, addr, UBC_ADDR_TXSUM)) begin
            wr_txsum = 1'b1;
        end else if (ubc_hit(wr_en, addr, UBC_ADDR_RXSUM)) begin
            wr_rxsum = 1'b1;
        end
    end

    // control word: mode and enable, both read back
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lin_mode        <= UBC_CTRL_RST[UBC_CTRL_LIN];
            checksum_enable <= UBC_CTRL_RST[UBC_CTRL_EN];
        end else if (wr_ctrl) begin
            lin_mode        <= wr_data[UBC_CTRL_LIN];
            checksum_enable <= wr_data[UBC_CTRL_EN];
        end
    end

    // transmit byte qualification
    always_comb begin
        tx_is_pid     = ubc_pid_slot(lin_mode, tx_state);
        tx_counts     = tx_byte_done
                        && ubc_counts(lin_mode, checksum_enable, tx_state);
        next_tx_state = ubc_walk(lin_mode, tx_frame_start, tx_byte_done,
                                 tx_state);
    end

    // receive byte qualification, same walk on its own state
    always_comb begin
        rx_is_pid     = ubc_pid_slot(lin_mode, rx_state);
        rx_counts     = rx_byte_done
                        && ubc_counts(lin_mode, checksum_enable, rx_state);
        next_rx_state = ubc_walk(lin_mode, rx_frame_start, rx_byte_done,
                                 rx_state);
    end

    // frame walkers; leaving lin mode parks them idle

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_state <= UBC_ST_IDLE;
        end else begin
            tx_state <= next_tx_state;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_state <= UBC_ST_IDLE;
        end else begin
            rx_state <= next_rx_state;
        end
    end

    // last pid seen, kept for software to compare against the sum
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_pid <= UBC_PID_RST;
        end else if (tx_byte_done && tx_is_pid) begin
            tx_pid <= tx_byte;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_pid <= UBC_PID_RST;
        end else if (rx_byte_done && rx_is_pid) begin
            rx_pid <= rx_byte;
        end
    end

    // byte counts restart on a sum write; a byte in that cycle still counts
    always_comb begin
        next_tx_count = ubc_step_count(wr_txsum, tx_counts, tx_count);
        next_rx_count = ubc_step_count(wr_rxsum, rx_counts, rx_count);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_count <= UBC_CNT_RST;
        end else begin
            tx_count <= next_tx_count;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_count <= UBC_CNT_RST;
        end else begin
            rx_count <= next_rx_count;
        end
    end

    // transmit sum
    ubc_sum_acc #(
        .W          (DW)
    ) u_tx_sum (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .add_en     (tx_counts),
        .add_byte   (tx_byte),
        .load       (wr_txsum),
        .load_value (wr_data),
        .sum        (tx_checksum)
    );

    // receive sum
    ubc_sum_acc #(
        .W          (DW)
    ) u_rx_sum (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .add_en     (rx_counts),
        .add_byte   (rx_byte),
        .load       (wr_rxsum),
        .load_value (wr_data),
        .sum        (rx_checksum)
    );

    // both walkers side by side; they sit idle outside lin mode
    always_comb begin
        status = UBC_READ_ZERO;
        status[UBC_STAT_TX_LO +: SW] = tx_state;
        status[UBC_STAT_RX_LO +: SW] = rx_state;
    end

    // read mux; unmapped offsets read zero, data valid the cycle after
    always_comb begin
        next_rd_data = UBC_READ_ZERO;
        if (!rd_en) begin
            next_rd_data = UBC_READ_ZERO;
        end else if (addr == UBC_ADDR_CTRL) begin
            next_rd_data[UBC_CTRL_LIN] = lin_mode;
            next_rd_data[UBC_CTRL_EN]  = checksum_enable;
        end else if (addr == UBC_ADDR_TXSUM) begin
            next_rd_data = tx_checksum;
        end else if (addr == UBC_ADDR_RXSUM) begin
            next_rd_data = rx_checksum;
        end else if (addr == UBC_ADDR_STAT) begin
            next_rd_data = status;
        end else if (addr == UBC_ADDR_TXCNT) begin
            next_rd_data = tx_count;
        end else if (addr == UBC_ADDR_RXCNT) begin
            next_rd_data = rx_count;
        end else if (addr == UBC_ADDR_TXPID) begin
            next_rd_data = tx_pid;
        end else if (addr == UBC_ADDR_RXPID) begin
            next_rd_data = rx_pid;
        end
    end

    // registered read: data stands one cycle, then drops to zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= UBC_READ_ZERO;
        end else begin
            rd_data <= next_rd_data;
        end
    end

endmodule

// ### verilog/ubc_pkg.sv
// package of register map, field layout and state codes for the checksum unit
package ubc_pkg;

    localparam int          UBC_ADDR_W     = 4;
    localparam int          UBC_DATA_W     = 8;

    localparam logic [3:0]  UBC_ADDR_CTRL  = 4'h0;
    localparam logic [3:0]  UBC_ADDR_TXSUM = 4'h1;
    localparam logic [3:0]  UBC_ADDR_RXSUM = 4'h2;
    localparam logic [3:0]  UBC_ADDR_STAT  = 4'h3;
    localparam logic [3:0]  UBC_ADDR_TXCNT = 4'h4;
    localparam logic [3:0]  UBC_ADDR_RXCNT = 4'h5;
    localparam logic [3:0]  UBC_ADDR_TXPID = 4'h6;
    localparam logic [3:0]  UBC_ADDR_RXPID = 4'h7;

    localparam int          UBC_CTRL_LIN   = 0;
    localparam int          UBC_CTRL_EN    = 1;
    localparam int          UBC_STAT_TX_LO = 0;
    localparam int          UBC_STAT_RX_LO = 3;

    localparam logic [7:0]  UBC_SUM_RST    = 8'h00;
    localparam logic [7:0]  UBC_CNT_RST    = 8'h00;
    localparam logic [7:0]  UBC_PID_RST    = 8'h00;
    localparam logic [1:0]  UBC_CTRL_RST   = 2'h0;
    localparam logic [7:0]  UBC_READ_ZERO  = 8'h00;
    localparam logic [7:0]  UBC_CNT_ONE    = 8'h01;

    typedef enum logic [2:0] {
        UBC_ST_IDLE = 3'b001,
        UBC_ST_PID  = 3'b010,
        UBC_ST_DATA = 3'b100
    } ubc_frame_t;

endpackage

// ### verilog/ubc_sum_acc.sv
// modulo-256 running byte sum with software load
`timescale 1ns/10ps
module ubc_sum_acc #(
    parameter int W = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic         add_en,
    input  wire logic [W-1:0] add_byte,
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    output logic      [W-1:0] sum
);
    import ubc_pkg::*;

    logic [W-1:0] base;

    // a byte finishing in the write cycle is added on top of the loaded value
    always_comb begin
        base = load ? load_value : sum;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sum <= W'(UBC_SUM_RST);
        end else if (add_en) begin
            sum <= W'(base + add_byte);
        end else if (load) begin
            sum <= load_value;
        end
    end

endmodule

// ### dv/ubc_line_peer.sv
// serial line peer: frame start and byte completion pulses
`timescale 1ns/10ps
module ubc_line_peer (
    input  wire logic       ref_clk,
    output logic            frame_start,
    output logic            byte_done,
    output logic [7:0]      data
);
    initial begin
        frame_start = 1'b0;
        byte_done   = 1'b0;
        data        = 8'h00;
    end
    // an idle line shows the inverse of its last value, so the old byte comes back every second idle cycle
    task automatic put(input logic fs, input logic bd, input logic [7:0] b);
        @(posedge ref_clk);
        frame_start <= fs;
        byte_done   <= bd;
        data        <= bd ? b : ~data;
    endtask
endmodule

// ### dv/ubc_checksum_monitor.sv
// port checker of the checksum unit, bound to its top
`timescale 1ns/10ps
module ubc_checksum_mon (
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_en,
    input wire logic [7:0] tx_byte,
    input wire logic       tx_frame_start,
    input wire logic       tx_byte_done,
    input wire logic [7:0] rx_byte,
    input wire logic       rx_frame_start,
    input wire logic       rx_byte_done,
    input wire logic [7:0] tx_checksum,
    input wire logic [7:0] rx_checksum,
    input wire logic       lin_mode,
    input wire logic       checksum_enable
);
    import ubc_pkg::*;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    wire logic tx_wr = wr_en && addr == UBC_ADDR_TXSUM;
    wire logic rx_wr = wr_en && addr == UBC_ADDR_RXSUM;
    wire logic lin_off = lin_mode && !checksum_enable;
    sequence s_tx_pid;
        lin_off && tx_frame_start && !tx_byte_done
            ##1 tx_byte_done && lin_off && !wr_en;
    endsequence
    sequence s_rx_pid;
        lin_off && rx_frame_start && !rx_byte_done
            ##1 rx_byte_done && lin_off && !wr_en;
    endsequence
    property p_tx_add;
        tx_byte_done && checksum_enable && !tx_wr
            |=> tx_checksum == 8'($past(tx_checksum) + $past(tx_byte));
    endproperty
    property p_rx_add;
        rx_byte_done && checksum_enable && !rx_wr
            |=> rx_checksum == 8'($past(rx_checksum) + $past(rx_byte));
    endproperty
    property p_tx_hold;
        tx_byte_done && !lin_mode && !checksum_enable && !tx_wr
            |=> $stable(tx_checksum);
    endproperty
    property p_rx_hold;
        rx_byte_done && !lin_mode && !checksum_enable && !rx_wr
            |=> $stable(rx_checksum);
    endproperty
    property p_tx_pid;
        s_tx_pid |=> $stable(tx_checksum);
    endproperty
    property p_rx_pid;
        s_rx_pid |=> $stable(rx_checksum);
    endproperty
    property p_tx_load;
        tx_wr && !tx_byte_done |=> tx_checksum == $past(wr_data);
    endproperty
    property p_rx_load;
        rx_wr && !rx_byte_done |=> rx_checksum == $past(wr_data);
    endproperty
    property p_zero;
        $rose(resetn) |-> tx_checksum == UBC_SUM_RST
            && rx_checksum == UBC_SUM_RST;
    endproperty
    a_tx_add: assert property (p_tx_add)
        else $error("tx sum add wrong");
    a_rx_add: assert property (p_rx_add)
        else $error("rx sum add wrong");
    a_tx_hold: assert property (p_tx_hold)
        else $error("tx sum moved while off");
    a_rx_hold: assert property (p_rx_hold)
        else $error("rx sum moved while off");
    a_tx_pid: assert property (p_tx_pid)
        else $error("tx pid was added");
    a_rx_pid: assert property (p_rx_pid)
        else $error("rx pid was added");
    a_tx_load: assert property (p_tx_load)
        else $error("tx sum load wrong");
    a_rx_load: assert property (p_rx_load)
        else $error("rx sum load wrong");
    a_zero: assert property (p_zero)
        else $error("sums not zero after reset");
endmodule
bind ubc_checksum ubc_checksum_mon u_mon (
    .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .tx_byte(tx_byte), .tx_frame_start(tx_frame_start),
    .tx_byte_done(tx_byte_done), .rx_byte(rx_byte),
    .rx_frame_start(rx_frame_start), .rx_byte_done(rx_byte_done),
    .tx_checksum(tx_checksum), .rx_checksum(rx_checksum),
    .lin_mode(lin_mode), .checksum_enable(checksum_enable)
);

// ### dv/ubc_checksum_test.sv
// self-checking bench of the serial byte checksum unit
`timescale 1ns/10ps
module ubc_checksum_test;
    import ubc_pkg::*;
    logic       ref_clk, resetn, wr_en, rd_en, lin_mode, checksum_enable;
    logic [3:0] addr;
    logic [7:0] wr_data, rd_data, tx_checksum, rx_checksum, tx_byte, rx_byte;
    logic       tx_frame_start, tx_byte_done, rx_frame_start, rx_byte_done;
    int         fail_count, samples_checked, seed;

    ubc_checksum u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .tx_byte(tx_byte),
        .tx_frame_start(tx_frame_start), .tx_byte_done(tx_byte_done),
        .rx_frame_start(rx_frame_start), .rx_byte_done(rx_byte_done),
        .rx_byte(rx_byte), .tx_checksum(tx_checksum),
        .rx_checksum(rx_checksum), .lin_mode(lin_mode),
        .checksum_enable(checksum_enable));
    ubc_line_peer u_tx (.ref_clk(ref_clk), .frame_start(tx_frame_start),
        .byte_done(tx_byte_done), .data(tx_byte));
    ubc_line_peer u_rx (.ref_clk(ref_clk), .frame_start(rx_frame_start),
        .byte_done(rx_byte_done), .data(rx_byte));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task check(input logic [7:0] seen, input logic [7:0] exp, string what);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] exp, string what);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 check(rd_data, exp, what);
    endtask
    task pair(input logic fs, bd, input logic [7:0] tb, rb);
        fork
            u_tx.put(fs, bd, tb);
            u_rx.put(fs, bd, rb);
        join
    endtask
    function automatic logic counted(input logic lin, en, pid);
        return en || (lin && !pid);
    endfunction
    // frame start is sent in every mode; off lin it must be ignored
    task automatic frame(input logic lin, input logic en);
        logic [7:0] tb, rb, te, re, nc, tp, rp, cw, st;
        te = 8'h00;
        re = 8'h00;
        nc = 8'h00;
        tp = 8'h00;
        rp = 8'h00;
        cw = {6'h00, en, lin};
        st = {2'b00, UBC_ST_IDLE, UBC_ST_IDLE};
        wr(UBC_ADDR_CTRL, cw);
        wr(UBC_ADDR_TXSUM, 8'h00);
        wr(UBC_ADDR_RXSUM, 8'h00);
        pair(1'b1, 1'b0, 8'h00, 8'h00);
        for (int i = 0; i < 6; i++) begin
            tb = (i == 1) ? 8'hff : 8'($random(seed));
            rb = (i == 2) ? 8'hff : 8'($random(seed));
            if (i == 0) begin
                tp = tb;
                rp = rb;
            end
            pair(1'b0, 1'b1, tb, rb);
            if (i == 3) pair(1'b0, 1'b0, 8'h00, 8'h00);
            if (counted(lin, en, i == 0)) begin
                te += tb;
                re += rb;
                nc += 8'h01;
            end
        end
        pair(1'b0, 1'b0, 8'h00, 8'h00);
        rd(UBC_ADDR_TXSUM, te, "tx_sum");
        rd(UBC_ADDR_RXSUM, re, "rx_sum");
        check(rx_checksum, re, "rx_port");
        check(tx_checksum, te, "tx_port");
        rd(UBC_ADDR_CTRL, cw, "ctrl");
        check({6'h00, checksum_enable, lin_mode}, cw, "ctrl_port");
        rd(UBC_ADDR_TXCNT, nc, "tx_count");
        rd(UBC_ADDR_RXCNT, nc, "rx_count");
        if (lin) begin
            st = {2'b00, UBC_ST_DATA, UBC_ST_DATA};
        end
        rd(UBC_ADDR_STAT, st, "status");
        if (lin) begin
            rd(UBC_ADDR_TXPID, tp, "tx_pid");
            rd(UBC_ADDR_RXPID, rp, "rx_pid");
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        seed = 46937;
        fail_count = 0;
        samples_checked = 0;
        {resetn, wr_en, rd_en, addr, wr_data} = 15'h0000;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(UBC_ADDR_TXSUM, UBC_SUM_RST, "tx_reset");
        rd(UBC_ADDR_RXSUM, UBC_SUM_RST, "rx_reset");
        for (int m = 0; m < 8; m++) begin
            frame(m[0], m[1]);
        end
        // sum write and counted byte on one edge: the byte lands on top
        fork
            wr(UBC_ADDR_TXSUM, 8'h10);
            begin
                pair(1'b0, 1'b1, 8'h22, 8'h33);
                pair(1'b0, 1'b0, 8'h00, 8'h00);
            end
        join
        rd(UBC_ADDR_TXSUM, 8'h32, "tx_load_add");
        rd(UBC_ADDR_TXCNT, 8'h01, "tx_count_load");
        wr(UBC_ADDR_TXSUM, 8'h5a);
        wr(UBC_ADDR_RXSUM, 8'ha5);
        rd(UBC_ADDR_TXSUM, 8'h5a, "tx_load");
        rd(UBC_ADDR_RXSUM, 8'ha5, "rx_load");
        @(posedge ref_clk);
        #1 check(rd_data, UBC_READ_ZERO, "rd_idle");
        rd(4'hc, UBC_READ_ZERO, "unmapped");
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(UBC_ADDR_TXSUM, UBC_SUM_RST, "tx_rereset");
        rd(UBC_ADDR_RXSUM, UBC_SUM_RST, "rx_rereset");
        print_verdict();
    end
endmodule
